// File: shared/rnb_pkg.sv
// shared constants for the receive national-bit and alarm interrupt block
package rnb_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] RNB_IDX_LINE_STATUS = 12'h036;
   localparam logic [11:0] RNB_IDX_SEL_EN = 12'h03b;
   localparam logic [11:0] RNB_IDX_NB_STAT = 12'h03c;
   localparam logic [11:0] RNB_IDX_CODEWORD = 12'h03d;
   localparam logic [11:0] RNB_IDX_PA_EN = 12'h03e;
   localparam logic [11:0] RNB_IDX_PA_STAT = 12'h03f;
   localparam int RNB_ADDR_W = 12;
   localparam int RNB_DATA_W = 32;
   localparam int RNB_NUM_SA = 5;
   localparam int RNB_NIB_W = 4;

   // natbit_select_and_irq_enable fields and register reset values
   localparam int RNB_SEL_LSB = 5;
   localparam int RNB_SEL_W = 3;
   localparam logic [7:0] RNB_SEL_EN_RST = 8'h00;
   localparam logic [7:0] RNB_PA_EN_RST = 8'h00;
   localparam logic [4:0] RNB_NB_STAT_RST = 5'h00;
   localparam logic [7:0] RNB_PA_STAT_RST = 8'h00;
   localparam logic [3:0] RNB_NIB_RST = 4'h0;

   // selector codes
   localparam logic [2:0] RNB_SEL_SA4 = 3'h4;
   localparam logic [2:0] RNB_SEL_SA5 = 3'h5;
   localparam logic [2:0] RNB_SEL_SA6 = 3'h6;
   localparam logic [2:0] RNB_SEL_SA7 = 3'h7;
   localparam logic [2:0] RNB_SEL_SA8 = 3'h0;

   // pulse/alarm field positions
   localparam int RNB_PA_OFFLINE = 7;
   localparam int RNB_PA_RAFEBE = 6;
   localparam int RNB_PA_CFEBE = 5;
   localparam int RNB_PA_LINKID = 4;
   localparam int RNB_PA_BFP = 3;
   localparam int RNB_PA_SMFP = 2;
   localparam int RNB_PA_CMFP = 1;
   localparam int RNB_PA_SIGMFP = 0;

   // line status register fields
   localparam int RNB_LS_OFFLINE = 3;
   localparam int RNB_LS_LINKID = 0;
endpackage

// File: shared/rnb_natbit_if.sv
// carrier between the top and one national-bit codeword tracker
`timescale 1ns/1ps
interface rnb_natbit_if;
   logic nfas_stb;
   logic submf_start;
   logic sa_bit;
   logic [3:0] nibble;
   logic changed;
   modport tracker (
      input nfas_stb,
      input submf_start,
      input sa_bit,
      output nibble,
      output changed
   );
   modport top (
      output nfas_stb,
      output submf_start,
      output sa_bit,
      input nibble,
      input changed
   );
endinterface

// File: rtl/rnb_natbit_deb.sv
// captures and debounces one national bit codeword per crc sub-multiframe
`timescale 1ns/1ps
module rnb_natbit_deb
   import rnb_pkg::*;
#(
   parameter int NIB_W = RNB_NIB_W
)
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   rnb_natbit_if.tracker nb
);
   logic [NIB_W-1:0] shift_ff;
   logic [2:0] cnt_ff;
   logic [NIB_W-1:0] cand_ff;
   logic cand_vld_ff;
   logic [NIB_W-1:0] nib_ff;
   logic chg_ff;
   logic full;

   assign full = (cnt_ff == 3'(NIB_W));

   // shift in nfas bits, earliest ends in the top bit
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         shift_ff <= RNB_NIB_RST;
         cnt_ff <= 3'h0;
      end
      else if (nb.submf_start)
      begin
         shift_ff <= RNB_NIB_RST;
         cnt_ff <= 3'h0;
      end
      else if (nb.nfas_stb && !full)
      begin
         shift_ff <= {shift_ff[NIB_W-2:0], nb.sa_bit}; // [R5]
         cnt_ff <= cnt_ff + 3'h1;
      end
   end

   // debounce: accept only two equal consecutive codewords
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cand_ff <= RNB_NIB_RST;
         cand_vld_ff <= 1'b0;
         nib_ff <= RNB_NIB_RST;
         chg_ff <= 1'b0;
      end
      else
      begin
         chg_ff <= 1'b0;
         if (nb.submf_start)
         begin
            cand_ff <= shift_ff;
            cand_vld_ff <= full;
            if (full && cand_vld_ff && cand_ff == shift_ff) // [R6]
            begin
               nib_ff <= shift_ff;
               chg_ff <= (shift_ff != nib_ff); // [R23]
            end
         end
      end
   end

   assign nb.nibble = nib_ff;
   assign nb.changed = chg_ff;
endmodule

// File: rtl/rnb_rx_natbit_irq.sv
// receive national-bit codeword and pulse/alarm interrupt block with apb registers
`timescale 1ns/1ps
// Overview of operation
// [R1] selector picks Sa4..Sa8 codeword; 010 reserved
// [R2] per-Sa enable gates codeword change onto pin
// [R3] software keeps enable clear on hdlc Sa bits
// [R4] codeword change sets flag; read clears flags
// [R5] codeword bits 3..0, earliest bit in 3
// [R6] codeword updates only on two equal codewords
// [R7] offline sync change enable gates pin
// [R8] offline out-of-sync toggle sets change flag
// [R9] link-id indication edge sets change flag
// [R10] link-id enable gates its flag onto pin
// [R11] remote alarm with febe onset flagged, maskable
// [R12] continuous febe onset flagged, maskable
// [R13] basic frame start flagged, enable gates pin
// [R14] sub-multiframe start pulse gated by enable
// [R15] crc multiframe start pulse gated by enable
// [R16] signaling multiframe start pulse gated by enable
// [R17] pulse/alarm status read clears all bits
// [R18] offline indication reads 1 when out of sync
// [R19] sub-multiframe start sets its flag
// [R20] crc multiframe start sets its flag
// [R21] signaling multiframe start sets its flag
// [R22] pin low while any enabled flag set
// [R23] change only when new codeword differs
module rnb_rx_natbit_irq
   import rnb_pkg::*;
#(
   parameter int NUM_SA = RNB_NUM_SA
)
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [RNB_ADDR_W-1:0] paddr_i,
   input wire logic [RNB_DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [RNB_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic nfas_stb_i,
   input wire logic [4:0] natbits_i,
   input wire logic basic_frame_start_i,
   input wire logic crc_submf_start_i,
   input wire logic crc_mf_start_i,
   input wire logic sig_mf_start_i,
   input wire logic offline_out_of_sync_ind_i,
   input wire logic remote_alarm_febe_i,
   input wire logic continuous_febe_i,
   input wire logic link_id_received_ind_i,
   output logic int_n_o
);
   logic [7:0] sel_en_ff;
   logic [7:0] pa_en_ff;
   logic [4:0] nb_stat_ff;
   logic [7:0] pa_stat_ff;
   logic [RNB_DATA_W-1:0] prdata_ff;
   logic offline_ff;
   logic link_ff;
   logic rafebe_ff;
   logic cfebe_ff;
   logic [4:0] nxt_nb_stat;
   logic [7:0] nxt_pa_stat;
   logic [7:0] pa_set;
   logic [4:0] nb_set;
   logic [NUM_SA-1:0][3:0] nibbles;
   logic [3:0] sel_nibble;
   logic [2:0] natbit_selector;
   logic [4:0] natbit_change_irq_enables;
   logic acc;
   logic wr;
   logic rd;
   logic hit;
   logic [RNB_ADDR_W-1:0] idx;
   logic [RNB_DATA_W-1:0] rd_mux;

   // one codeword tracker per national bit, Sa4 first
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SA; gi++)
      begin : g_sa
         rnb_natbit_if nb_if ();
         assign nb_if.nfas_stb = nfas_stb_i;
         assign nb_if.submf_start = crc_submf_start_i;
         assign nb_if.sa_bit = natbits_i[NUM_SA-1-gi];
         assign nibbles[gi] = nb_if.nibble;
         assign nb_set[NUM_SA-1-gi] = nb_if.changed; // [R4]
         rnb_natbit_deb #(
            .NIB_W(RNB_NIB_W)
         ) u_deb (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .nb(nb_if.tracker)
         );
      end
   endgenerate

   // apb decode; word index is byte address over four
   assign idx = {2'b00, paddr_i[RNB_ADDR_W-1:2]};
   assign acc = psel_i && penable_i;
   assign wr = acc && pwrite_i;
   assign rd = acc && !pwrite_i;
   assign pready_o = 1'b1;

   always_comb
   begin
      hit = 1'b1;
      case (idx)
         RNB_IDX_LINE_STATUS,
         RNB_IDX_SEL_EN,
         RNB_IDX_NB_STAT,
         RNB_IDX_CODEWORD,
         RNB_IDX_PA_EN,
         RNB_IDX_PA_STAT:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
      if (paddr_i[1:0] != 2'b00)
      begin
         hit = 1'b0;
      end
   end

   assign pslverr_o = acc && !hit;

   assign natbit_selector = sel_en_ff[RNB_SEL_LSB +: RNB_SEL_W];
   assign natbit_change_irq_enables = sel_en_ff[4:0];

   // codeword view follows the selector
   always_comb
   begin
      case (natbit_selector) // [R1]
         RNB_SEL_SA4:
            sel_nibble = nibbles[0];
         RNB_SEL_SA5:
            sel_nibble = nibbles[1];
         RNB_SEL_SA6:
            sel_nibble = nibbles[2];
         RNB_SEL_SA7:
            sel_nibble = nibbles[3];
         RNB_SEL_SA8:
            sel_nibble = nibbles[4];
         default:
            sel_nibble = RNB_NIB_RST;
      endcase
   end

   // read data mux
   always_comb
   begin
      rd_mux = '0;
      case (idx)
         RNB_IDX_LINE_STATUS:
         begin
            rd_mux[RNB_LS_OFFLINE] = offline_ff; // [R18]
            rd_mux[RNB_LS_LINKID] = link_ff;
         end
         RNB_IDX_SEL_EN:
            rd_mux[7:0] = sel_en_ff;
         RNB_IDX_NB_STAT:
            rd_mux[4:0] = nb_stat_ff;
         RNB_IDX_CODEWORD:
            rd_mux[3:0] = sel_nibble; // [R5]
         RNB_IDX_PA_EN:
            rd_mux[7:0] = pa_en_ff;
         RNB_IDX_PA_STAT:
            rd_mux[7:0] = pa_stat_ff;
         default:
            rd_mux = '0;
      endcase
   end

   // read data registered during the setup cycle
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prdata_ff <= '0;
      end
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         prdata_ff <= rd_mux;
      end
   end

   assign prdata_o = prdata_ff;

   // control registers, low byte lane only
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sel_en_ff <= RNB_SEL_EN_RST;
         pa_en_ff <= RNB_PA_EN_RST;
      end
      else if (wr && pstrb_i[0])
      begin
         if (idx == RNB_IDX_SEL_EN)
         begin
            sel_en_ff <= pwdata_i[7:0];
         end
         if (idx == RNB_IDX_PA_EN)
         begin
            pa_en_ff <= pwdata_i[7:0];
         end
      end
   end

   // previous levels for transition detection
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         offline_ff <= 1'b0;
         link_ff <= 1'b0;
         rafebe_ff <= 1'b0;
         cfebe_ff <= 1'b0;
      end
      else
      begin
         offline_ff <= offline_out_of_sync_ind_i;
         link_ff <= link_id_received_ind_i;
         rafebe_ff <= remote_alarm_febe_i;
         cfebe_ff <= continuous_febe_i;
      end
   end

   // pulse/alarm event sources
   always_comb
   begin
      pa_set = 8'h00;
      pa_set[RNB_PA_OFFLINE] = offline_out_of_sync_ind_i ^ offline_ff; // [R8]
      pa_set[RNB_PA_RAFEBE] = remote_alarm_febe_i && !rafebe_ff; // [R11]
      pa_set[RNB_PA_CFEBE] = continuous_febe_i && !cfebe_ff; // [R12]
      pa_set[RNB_PA_LINKID] = link_id_received_ind_i ^ link_ff; // [R9]
      pa_set[RNB_PA_BFP] = basic_frame_start_i; // [R13]
      pa_set[RNB_PA_SMFP] = crc_submf_start_i; // [R19]
      pa_set[RNB_PA_CMFP] = crc_mf_start_i; // [R20]
      pa_set[RNB_PA_SIGMFP] = sig_mf_start_i; // [R21]
   end

   // sticky flags; a new event wins over the read clear
   always_comb
   begin
      nxt_nb_stat = nb_stat_ff;
      nxt_pa_stat = pa_stat_ff;
      if (rd && idx == RNB_IDX_NB_STAT && paddr_i[1:0] == 2'b00)
      begin
         nxt_nb_stat = RNB_NB_STAT_RST; // [R4]
      end
      if (rd && idx == RNB_IDX_PA_STAT && paddr_i[1:0] == 2'b00)
      begin
         nxt_pa_stat = RNB_PA_STAT_RST; // [R17]
      end
      nxt_nb_stat = nxt_nb_stat | nb_set;
      nxt_pa_stat = nxt_pa_stat | pa_set;
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         nb_stat_ff <= RNB_NB_STAT_RST;
         pa_stat_ff <= RNB_PA_STAT_RST;
      end
      else
      begin
         nb_stat_ff <= nxt_nb_stat;
         pa_stat_ff <= nxt_pa_stat;
      end
   end

   // interrupt pin, active low
   // enable bit 7 covers offline change, bit 4 link-id, bits 3..0 frame pulses
   // [R7] [R10] [R14] [R15] [R16] [R3]
   assign int_n_o = ~(|(nb_stat_ff & natbit_change_irq_enables) // [R2]
                     | |(pa_stat_ff & pa_en_ff)); // [R22]
endmodule

// File: bench/rnb_line_model.sv
// line-side model: national bits, frame start pulses and alarm levels
`timescale 1ns/1ps
module rnb_line_model (
   input wire logic clk_i,
   output logic nfas_stb_o,
   output logic [4:0] natbits_o,
   output logic [3:0] pls_o,
   output logic [3:0] lv_o
);
   initial
   begin
      nfas_stb_o = 1'b0;
      natbits_o = 5'h00;
      pls_o = 4'h0;
      lv_o = 4'h0;
   end
   task automatic pulse(input int i);
      @(posedge clk_i);
      pls_o[i] <= 1'b1;
      @(posedge clk_i);
      pls_o[i] <= 1'b0;
   endtask
   task automatic level(input int i, input logic v);
      @(posedge clk_i);
      lv_o[i] <= v;
   endtask
   task automatic submf(input logic [4:0][3:0] c);
      for (int j = 0; j < 4; j++)
      begin
         @(posedge clk_i);
         nfas_stb_o <= 1'b1;
         for (int s = 0; s < 5; s++)
            natbits_o[4 - s] <= c[s][3 - j];
         @(posedge clk_i);
         nfas_stb_o <= 1'b0;
         natbits_o <= ~natbits_o;
      end
      pulse(2);
   endtask
endmodule

// File: bench/rnb_rx_natbit_irq_chk.sv
// assertions on the ports of the national-bit and pulse/alarm interrupt block
`timescale 1ns/1ps
module rnb_rx_natbit_irq_chk
   import rnb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [RNB_ADDR_W-1:0] paddr_i,
   input wire logic [RNB_DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic basic_frame_start_i,
   input wire logic crc_submf_start_i,
   input wire logic crc_mf_start_i,
   input wire logic sig_mf_start_i,
   input wire logic offline_out_of_sync_ind_i,
   input wire logic remote_alarm_febe_i,
   input wire logic continuous_febe_i,
   input wire logic link_id_received_ind_i,
   input wire logic int_n_o
);
   logic [7:0] pa_en_ff;
   logic [4:0] sa_en_ff;
   wire logic acc = psel_i && penable_i;
   wire logic wr = acc && pwrite_i && pstrb_i[0];
   wire logic [3:0] lv = {offline_out_of_sync_ind_i, remote_alarm_febe_i, continuous_febe_i,
      link_id_received_ind_i};
   always_ff @(posedge ref_clk_i or negedge rstn_i)
      if (!rstn_i)
         pa_en_ff <= 8'h00;
      else if (wr && paddr_i == 12'h0f8)
         pa_en_ff <= pwdata_i[7:0];
   always_ff @(posedge ref_clk_i or negedge rstn_i)
      if (!rstn_i)
         sa_en_ff <= 5'h00;
      else if (wr && paddr_i == 12'h0ec)
         sa_en_ff <= pwdata_i[4:0];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_bfp_irq: assert property (basic_frame_start_i && pa_en_ff[3] |=> !int_n_o)
      else $error("frame pulse irq missing");
   a_smf_irq: assert property (crc_submf_start_i && pa_en_ff[2] |=> !int_n_o)
      else $error("submf pulse irq missing");
   a_cmf_irq: assert property (crc_mf_start_i && pa_en_ff[1] |=> !int_n_o)
      else $error("crc mf pulse irq missing");
   a_sigmf_irq: assert property (sig_mf_start_i && pa_en_ff[0] |=> !int_n_o)
      else $error("sig mf pulse irq missing");
   a_offline_irq: assert property ($changed(lv[3]) && pa_en_ff[7] |-> ##[1:2] !int_n_o)
      else $error("offline change irq missing");
   a_link_irq: assert property ($changed(lv[0]) && pa_en_ff[4] |-> ##[1:2] !int_n_o)
      else $error("link id irq missing");
   a_rafebe_irq: assert property ($rose(lv[2]) && pa_en_ff[6] |-> ##[1:2] !int_n_o)
      else $error("alarm febe irq missing");
   a_idle_high: assert property (pa_en_ff == 8'h00 && sa_en_ff == 5'h00 |-> int_n_o)
      else $error("irq low while masked");
   a_read_clear: assert property (acc && !pwrite_i && paddr_i == 12'h0fc && sa_en_ff == 5'h00
      && !basic_frame_start_i && !crc_submf_start_i && !crc_mf_start_i && !sig_mf_start_i
      && $stable(lv) && lv == $past(lv, 2) |=> int_n_o) else $error("irq kept after status read");
endmodule
bind rnb_rx_natbit_irq rnb_rx_natbit_irq_chk chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .basic_frame_start_i(basic_frame_start_i),
   .crc_submf_start_i(crc_submf_start_i), .crc_mf_start_i(crc_mf_start_i),
   .sig_mf_start_i(sig_mf_start_i), .continuous_febe_i(continuous_febe_i),
   .offline_out_of_sync_ind_i(offline_out_of_sync_ind_i), .remote_alarm_febe_i(remote_alarm_febe_i),
   .link_id_received_ind_i(link_id_received_ind_i), .int_n_o(int_n_o));

// File: bench/tb.sv
// self-checking bench for the national-bit and pulse/alarm interrupt block
`timescale 1ns/1ps
module tb;
   import rnb_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, int_n, nfas, er;
   logic [4:0] natbits;
   logic [3:0] pls, lv;
   logic [4:0][3:0] held, nw;
   logic [7:0] exp8;
   logic [2:0] selc [5] = '{RNB_SEL_SA4, RNB_SEL_SA5, RNB_SEL_SA6, RNB_SEL_SA7, RNB_SEL_SA8};
   int fail_count = 0;
   int n_checks = 0;
   initial forever #20 ref_clk_i = ~ref_clk_i;
   rnb_rx_natbit_irq dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .nfas_stb_i(nfas),
      .natbits_i(natbits), .basic_frame_start_i(pls[3]), .crc_submf_start_i(pls[2]),
      .crc_mf_start_i(pls[1]), .sig_mf_start_i(pls[0]), .offline_out_of_sync_ind_i(lv[3]),
      .remote_alarm_febe_i(lv[2]), .continuous_febe_i(lv[1]), .link_id_received_ind_i(lv[0]),
      .int_n_o(int_n));
   rnb_line_model line (.clk_i(ref_clk_i), .nfas_stb_o(nfas), .natbits_o(natbits), .pls_o(pls),
      .lv_o(lv));
   task automatic report_and_stop();
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
      @(negedge ref_clk_i);
   endtask
   function automatic logic [7:0] diff(input logic [4:0][3:0] a, input logic [4:0][3:0] b);
      diff = 8'h00;
      for (int s = 0; s < 5; s++)
         diff[4 - s] = (a[s] != b[s]);
   endfunction
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      logic [4:0] en;
      en = 5'($urandom(15));
      held = '0;
      repeat (8) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      rd_chk("sel_en reset", 12'h0ec, 32'h0);
      rd_chk("pa_en reset", 12'h0f8, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      for (int s = 0; s < 5; s++)
      begin
         nw = (s == 0) ? 20'hfffff : 20'($urandom);
         en = 5'($urandom);
         apb(1'b1, 12'h0ec, {24'h0, selc[s], en});
         rd_chk("sel_en rw", 12'h0ec, {24'h0, selc[s], en});
         // breaker codeword differs per nibble from the last accepted one
         line.submf(held ^ 20'hfffff);
         repeat (3) @(posedge ref_clk_i);
         rd_chk("codeword held", 12'h0f4, {28'h0, held[s]});
         line.submf(nw);
         line.submf(nw);
         repeat (3) @(negedge ref_clk_i);
         exp8 = diff(nw, held);
         chk("sa irq", {31'h0, int_n}, {31'h0, ~|(exp8[4:0] & en)});
         rd_chk("codeword", 12'h0f4, {28'h0, nw[s]});
         rd_chk("sa flags", 12'h0f0, {24'h0, exp8});
         rd_chk("sa flags clear", 12'h0f0, 32'h0);
         held = nw;
      end
      apb(1'b1, 12'h0ec, 32'h40);
      rd_chk("reserved sel", 12'h0f4, 32'h0);
      apb(1'b1, 12'h0ec, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 12'h0f8, {31'h0, i[0]} << (i / 2));
         line.pulse(i / 2);
         @(negedge ref_clk_i);
         chk("pulse irq", {31'h0, int_n}, {31'h0, ~i[0]});
         rd_chk("pulse flag", 12'h0fc, 32'h1 << (i / 2));
         chk("pulse irq clear", {31'h0, int_n}, 32'h1);
      end
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 12'h0f8, 32'h10 << (i / 2));
         line.level(i / 2, ~i[0]);
         repeat (3) @(negedge ref_clk_i);
         exp8 = (i[0] && (i / 2 == 1 || i / 2 == 2)) ? 8'h00 : 8'h10 << (i / 2);
         chk("level irq", {31'h0, int_n}, {31'h0, exp8 == 8'h00});
         if (i == 6)
            rd_chk("line status", 12'h0d8, 32'h8);
         rd_chk("level flag", 12'h0fc, {24'h0, exp8});
      end
      report_and_stop();
   end
endmodule
